//--- ccc_status_caps_handler.sv
// Target-side handler for the address-assignment, status-read and
// capability-read common command codes. Assumes the target address and
// the register map live outside; clears arrive as one-cycle pulses.
//
// Operation
// - Address-assignment accepted only in two-wire mode, with command-code timing.
// - In the faster mode the address-assignment code is ignored completely.
// - Code 0x29 sets mode bit 5; effective at the next Start after STOP.
// - Address-assignment carries no checksum byte on either side.
// - Status read 0x90, then repeated Start with our address, only in fast mode.
// - In two-wire mode the status-read code is not acknowledged nor executed.
// - Status bytes: checksum flag bit 7; parity bit 5, pending code bits 3:0.
// - Checksum restarts at each Start and skips the broadcast write byte.
// - Answering the status read never clears any of its flags.
// - Flags clear by write-one to clear bits 1 and 0, or global clear.
// - Condition still present at a clear sets the flag and pending code again.
// - Pending code clears whenever clearing drops the interrupt status.
// - With checksums, host sends one after the code, device after its data.
// - After a parity or checksum error, NACK the repeated-Start transaction.
// - Capability read returns two bytes, most significant first.
// - Capability bit 2 of the first byte is one; all else zero.
`timescale 1ns/10ps
`default_nettype none

module ccc_status_caps_handler
  import ccc_status_caps_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  input  wire logic [6:0] i_target_address,
  input  wire logic       i_pec_en,
  input  wire logic [1:0] i_error_clear_wr,
  input  wire logic       i_global_clear,
  input  wire logic       i_chk_cond,
  input  wire logic       i_par_cond,
  output logic            o_sda_out,
  output logic            o_sda_oe,
  output logic            o_mode_i3c,
  output logic            o_checksum_error_flag,
  output logic            o_parity_error_flag,
  output logic [3:0]      o_pending_irq,
  output logic            o_ibi_status
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_CODE, ST_PEC_IN, ST_READ, ST_SKIP
  } link_state_t;

  line_evt_t   ev;
  link_state_t state_ff, nxt_state;
  logic [3:0]  bit_cnt_ff, nxt_bit_cnt;
  logic [7:0]  shift_ff, nxt_shift;
  logic [7:0]  tx_sh_ff, nxt_tx_sh;
  logic [7:0]  cmd_ff, nxt_cmd;
  logic [7:0]  crc_ff, nxt_crc;
  logic [1:0]  idx_ff, nxt_idx;
  logic        ack_ff, nxt_ack;
  logic        cmd_ready_ff, nxt_cmd_ready;
  logic        err_txn_ff, nxt_err_txn;
  logic        nack_ff, nxt_nack;
  logic        mode_pend_ff, nxt_mode_pend;
  logic        mode_armed_ff, nxt_mode_armed;
  logic        mode_ff, nxt_mode;
  logic        sda_out_ff, nxt_sda_out;
  logic        sda_oe_ff, nxt_sda_oe;
  logic        chk_evt, par_evt;
  logic [7:0]  rx_byte;
  logic [1:0]  last_idx;
  status_t     stat_ff, nxt_stat;
  bus_line_sync #(
    .STAGES (2)
  ) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .i_scl     (i_scl),
    .i_sda     (i_sda),
    .o_evt     (ev)
  );
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crc8
  // Status is sampled at each byte load, so a flag set mid-read shows next time
  function automatic logic [7:0] tx_pick(input logic [7:0] cmd, input logic [1:0] idx,
                                         input status_t st, input logic [7:0] crc);
    logic [7:0] b;
    b = 8'h00;
    if (idx == LAST_IDX_PEC) begin
      b = crc;
    end else if (cmd == CODE_GETCAP) begin
      b = (idx == 2'h0) ? CAP_MSB : CAP_LSB;
    end else begin
      if (idx == 2'h0) begin
        b[STAT_CHK_BIT] = st.chk_err;
      end else begin
        b[STAT_PAR_BIT] = st.par_err;
        b[3:0]          = st.pend;
      end
    end
    return b;
  endfunction : tx_pick
  assign rx_byte  = {shift_ff[6:0], ev.sda};
  assign last_idx = i_pec_en ? LAST_IDX_PEC : LAST_IDX_PLAIN;
  always_comb begin
    nxt_state      = state_ff;
    nxt_bit_cnt    = bit_cnt_ff;
    nxt_shift      = shift_ff;
    nxt_tx_sh      = tx_sh_ff;
    nxt_cmd        = cmd_ff;
    nxt_crc        = crc_ff;
    nxt_idx        = idx_ff;
    nxt_ack        = ack_ff;
    nxt_cmd_ready  = cmd_ready_ff;
    nxt_err_txn    = err_txn_ff;
    nxt_nack       = nack_ff;
    nxt_mode_pend  = mode_pend_ff;
    nxt_mode_armed = mode_armed_ff;
    nxt_mode       = mode_ff;
    nxt_sda_out    = sda_out_ff;
    nxt_sda_oe     = sda_oe_ff;
    chk_evt        = 1'b0;
    par_evt        = 1'b0;
    if (ev.stop) begin
      nxt_state     = ST_IDLE;
      nxt_bit_cnt   = 4'h0;
      nxt_sda_oe    = 1'b0;
      nxt_cmd_ready = 1'b0;
      nxt_err_txn   = 1'b0;
      nxt_nack      = 1'b0;
      if (mode_pend_ff) begin
        nxt_mode_armed = 1'b1;
        nxt_mode_pend  = 1'b0;
      end
    end else if (ev.start) begin
      // Mode switch waits for a fresh Start, never a repeated one
      if (state_ff == ST_IDLE && mode_armed_ff) begin
        nxt_mode       = 1'b1;
        nxt_mode_armed = 1'b0;
      end
      nxt_nack    = (state_ff != ST_IDLE) && (err_txn_ff || nack_ff);
      nxt_err_txn = 1'b0;
      nxt_crc     = CRC_INIT;
      nxt_bit_cnt = 4'h0;
      nxt_ack     = 1'b0;
      nxt_sda_oe  = 1'b0;
      nxt_state   = ST_ADDR;
    end else if (ev.scl_rise) begin
      unique case (state_ff)
        ST_ADDR, ST_CODE, ST_PEC_IN: begin
          if (bit_cnt_ff < BIT_LAST) begin
            nxt_shift   = rx_byte;
            nxt_bit_cnt = 4'(bit_cnt_ff + 4'h1);
            if (bit_cnt_ff == 4'h7) begin
              if (state_ff == ST_ADDR) begin
                nxt_ack = ((rx_byte == {BCAST_ADDR, 1'b0})
                          || (rx_byte == {i_target_address, 1'b1} && cmd_ready_ff && mode_ff))
                          && !nack_ff;
                if (rx_byte != {BCAST_ADDR, 1'b0}) begin
                  nxt_crc = crc8(crc_ff, rx_byte);
                end
              end else if (state_ff == ST_CODE) begin
                // Two-wire mode acks only the assignment code
                nxt_ack = !mode_ff && rx_byte == CODE_SETAASA;
                nxt_crc = crc8(crc_ff, rx_byte);
              end else begin
                nxt_ack = 1'b0;
              end
            end
          end else begin
            nxt_bit_cnt = 4'h0;
            unique case (state_ff)
              ST_ADDR: begin
                if (!ack_ff) begin
                  nxt_state = ST_SKIP;
                end else if (shift_ff == {BCAST_ADDR, 1'b0}) begin
                  nxt_state = ST_CODE;
                end else begin
                  nxt_state = ST_READ;
                  nxt_idx   = 2'h0;
                  nxt_tx_sh = tx_pick(cmd_ff, 2'h0, stat_ff, crc_ff);
                  nxt_crc   = crc8(crc_ff, nxt_tx_sh);
                end
              end
              ST_CODE: begin
                nxt_state = ST_SKIP;
                if (!mode_ff) begin
                  if (ack_ff) begin
                    nxt_mode_pend = 1'b1;
                  end
                end else if (!(^{shift_ff, ev.sda})) begin
                  par_evt     = 1'b1;
                  nxt_err_txn = 1'b1;
                end else if (shift_ff == CODE_GETSTATUS || shift_ff == CODE_GETCAP) begin
                  nxt_cmd = shift_ff;
                  if (i_pec_en) begin
                    nxt_state = ST_PEC_IN;
                  end else begin
                    nxt_cmd_ready = 1'b1;
                  end
                end
              end
              ST_PEC_IN: begin
                nxt_state = ST_SKIP;
                if (!(^{shift_ff, ev.sda})) begin
                  par_evt     = 1'b1;
                  nxt_err_txn = 1'b1;
                end else if (shift_ff != crc_ff) begin
                  chk_evt     = 1'b1;
                  nxt_err_txn = 1'b1;
                end else begin
                  nxt_cmd_ready = 1'b1;
                end
              end
              default: begin
                nxt_state = ST_SKIP;
              end
            endcase
          end
        end
        ST_READ: begin
          if (bit_cnt_ff < BIT_LAST) begin
            nxt_bit_cnt = 4'(bit_cnt_ff + 4'h1);
          end else begin
            nxt_bit_cnt = 4'h0;
            if (idx_ff == last_idx) begin
              nxt_state     = ST_SKIP;
              nxt_cmd_ready = 1'b0;
            end else begin
              nxt_idx   = 2'(idx_ff + 2'h1);
              nxt_tx_sh = tx_pick(cmd_ff, nxt_idx, stat_ff, crc_ff);
              nxt_crc   = crc8(crc_ff, nxt_tx_sh);
            end
          end
        end
        ST_IDLE, ST_SKIP: begin
          nxt_bit_cnt = 4'h0;
        end
      endcase
    end else if (ev.scl_fall) begin
      unique case (state_ff)
        ST_ADDR, ST_CODE, ST_PEC_IN: begin
          nxt_sda_oe  = (bit_cnt_ff == BIT_LAST) && ack_ff;
          nxt_sda_out = 1'b0;
        end
        ST_READ: begin
          nxt_sda_oe = 1'b1;
          if (bit_cnt_ff < BIT_LAST) begin
            nxt_sda_out = tx_sh_ff[7];
            nxt_tx_sh   = {tx_sh_ff[6:0], 1'b0};
          end else begin
            nxt_sda_out = (idx_ff != last_idx);
          end
        end
        ST_IDLE, ST_SKIP: begin
          nxt_sda_oe  = 1'b0;
          nxt_sda_out = 1'b0;
        end
      endcase
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_ff      <= ST_IDLE;
      bit_cnt_ff    <= 4'h0;
      shift_ff      <= 8'h00;
      tx_sh_ff      <= 8'h00;
      cmd_ff        <= 8'h00;
      crc_ff        <= CRC_INIT;
      idx_ff        <= 2'h0;
      ack_ff        <= 1'b0;
      cmd_ready_ff  <= 1'b0;
      err_txn_ff    <= 1'b0;
      nack_ff       <= 1'b0;
      mode_pend_ff  <= 1'b0;
      mode_armed_ff <= 1'b0;
      mode_ff       <= 1'b0;
      sda_out_ff    <= 1'b0;
      sda_oe_ff     <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      bit_cnt_ff    <= nxt_bit_cnt;
      shift_ff      <= nxt_shift;
      tx_sh_ff      <= nxt_tx_sh;
      cmd_ff        <= nxt_cmd;
      crc_ff        <= nxt_crc;
      idx_ff        <= nxt_idx;
      ack_ff        <= nxt_ack;
      cmd_ready_ff  <= nxt_cmd_ready;
      err_txn_ff    <= nxt_err_txn;
      nack_ff       <= nxt_nack;
      mode_pend_ff  <= nxt_mode_pend;
      mode_armed_ff <= nxt_mode_armed;
      mode_ff       <= nxt_mode;
      sda_out_ff    <= nxt_sda_out;
      sda_oe_ff     <= nxt_sda_oe;
    end
  end
  // Set beats clear so an event in the clearing cycle survives
  always_comb begin
    nxt_stat         = stat_ff;
    nxt_stat.chk_err = (stat_ff.chk_err & ~(i_error_clear_wr[CLR_CHK_BIT] | i_global_clear))
                       | chk_evt | i_chk_cond;
    nxt_stat.par_err = (stat_ff.par_err & ~(i_error_clear_wr[CLR_PAR_BIT] | i_global_clear))
                       | par_evt | i_par_cond;
    nxt_stat.ibi     = nxt_stat.chk_err | nxt_stat.par_err;
    nxt_stat.pend    = nxt_stat.ibi ? PEND_SET : PEND_NONE;
  end
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stat_ff <= '0;
    end else begin
      stat_ff <= nxt_stat;
    end
  end
  assign o_sda_out             = sda_out_ff;
  assign o_sda_oe              = sda_oe_ff;
  assign o_mode_i3c            = mode_ff;
  assign o_checksum_error_flag = stat_ff.chk_err;
  assign o_parity_error_flag   = stat_ff.par_err;
  assign o_pending_irq         = stat_ff.pend;
  assign o_ibi_status          = stat_ff.ibi;
  chk_mode_at_start: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    $rose(mode_ff) |-> $past(ev.start) && $past(mode_armed_ff))
    else $error("Mode changed without a fresh Start");
  chk_pend_only_i2c: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    $rose(mode_pend_ff) |-> !mode_ff && $past(shift_ff) == CODE_SETAASA)
    else $error("Mode request taken outside two-wire mode");
  chk_fast_ignores: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    mode_ff |=> !$rose(mode_pend_ff))
    else $error("Assignment code acted on in fast mode");
  chk_no_status_ack: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (state_ff == ST_CODE && !mode_ff && bit_cnt_ff == BIT_LAST && shift_ff == CODE_GETSTATUS)
    |-> !ack_ff ##1 !(sda_oe_ff && !sda_out_ff && state_ff == ST_CODE))
    else $error("Status code acknowledged in two-wire mode");
  chk_flag_hold: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    $fell(stat_ff.chk_err) |-> $past(i_error_clear_wr[CLR_CHK_BIT] | i_global_clear))
    else $error("Checksum flag dropped without a clear");
  chk_set_wins: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (i_par_cond && i_error_clear_wr[CLR_PAR_BIT]) |=> stat_ff.par_err && stat_ff.pend == PEND_SET)
    else $error("Clear beat a present parity condition");
  chk_pend_tracks: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    $fell(stat_ff.ibi) |-> stat_ff.pend == PEND_NONE && $past(stat_ff.pend) == PEND_SET)
    else $error("Pending code out of step with interrupt status");
  chk_nack_after_err: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (ev.start && err_txn_ff && state_ff != ST_IDLE) |=> nack_ff ##1 !ack_ff[*8])
    else $error("Acknowledged after an errored transaction");
  chk_tbit_value: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (ev.scl_fall && state_ff == ST_READ && bit_cnt_ff == BIT_LAST)
    |=> sda_oe_ff && sda_out_ff == ($past(idx_ff) != $past(last_idx)))
    else $error("Transition bit wrong for byte position");
  chk_cap_first: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    ($rose(state_ff == ST_READ) && cmd_ff == CODE_GETCAP) |-> tx_sh_ff == CAP_MSB)
    else $error("Capability first byte wrong");

endmodule : ccc_status_caps_handler

`default_nettype wire

//--- ccc_status_caps_pkg.sv
// Constants and carrier types for the command-code handler.
// Assumes a single system clock domain and sampled bus pins.
`default_nettype none

package ccc_status_caps_pkg;

  localparam logic [6:0] BCAST_ADDR     = 7'h7e;
  localparam logic [7:0] CODE_SETAASA   = 8'h29;
  localparam logic [7:0] CODE_GETSTATUS = 8'h90;
  localparam logic [7:0] CODE_GETCAP    = 8'he0;

  // Status byte layout
  localparam int         STAT_CHK_BIT   = 7;
  localparam int         STAT_PAR_BIT   = 5;
  localparam logic [3:0] PEND_NONE      = 4'h0;
  localparam logic [3:0] PEND_SET       = 4'h1;

  // Capability bytes: only timer-based reset advertised
  localparam logic [7:0] CAP_MSB        = 8'h04;
  localparam logic [7:0] CAP_LSB        = 8'h00;

  // mode_config_reg and error_clear_reg bit positions
  localparam int         MODE_I3C_BIT   = 5;
  localparam int         CLR_CHK_BIT    = 1;
  localparam int         CLR_PAR_BIT    = 0;

  // Checksum: CRC-8, polynomial x^8+x^2+x+1
  localparam logic [7:0] CRC_POLY       = 8'h07;
  localparam logic [7:0] CRC_INIT       = 8'h00;

  // Last byte index of a read answer; last bit index of a byte frame
  localparam logic [1:0] LAST_IDX_PLAIN = 2'h1;
  localparam logic [1:0] LAST_IDX_PEC   = 2'h2;
  localparam logic [3:0] BIT_LAST       = 4'h8;

  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } line_evt_t;

  typedef struct packed {
    logic       chk_err;
    logic       par_err;
    logic [3:0] pend;
    logic       ibi;
  } status_t;

endpackage : ccc_status_caps_pkg

`default_nettype wire

//--- bus_line_sync.sv
// Two-flop synchronisers for the bus clock and data pins plus
// edge, Start and STOP detection. Assumes pins are asynchronous.
`timescale 1ns/10ps
`default_nettype none

module bus_line_sync
  import ccc_status_caps_pkg::*;
#(
  parameter int STAGES = 2
) (
  input  wire logic      i_sys_clk,
  input  wire logic      i_arst_n,
  input  wire logic      i_scl,
  input  wire logic      i_sda,
  output var line_evt_t  o_evt
);

  if (STAGES < 2) begin : g_bad_stages
    $error("bus_line_sync needs at least two stages");
  end

  logic [1:0] pin_in;
  logic [1:0] sync_q;
  logic [1:0] prev_ff;
  logic [1:0] nxt_prev;

  assign pin_in = {i_scl, i_sda};

  for (genvar g = 0; g < 2; g++) begin : g_sync
    logic [STAGES-1:0] chain_ff;
    logic [STAGES-1:0] nxt_chain;
    always_comb begin
      nxt_chain = {chain_ff[STAGES-2:0], pin_in[g]};
    end
    // Idle bus is high; reset to that to avoid a false Start
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        chain_ff <= '1;
      end else begin
        chain_ff <= nxt_chain;
      end
    end
    assign sync_q[g] = chain_ff[STAGES-1];
  end

  always_comb begin
    nxt_prev = sync_q;
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prev_ff <= 2'h3;
    end else begin
      prev_ff <= nxt_prev;
    end
  end

  always_comb begin
    o_evt.scl      = sync_q[1];
    o_evt.sda      = sync_q[0];
    o_evt.scl_rise = sync_q[1] & ~prev_ff[1];
    o_evt.scl_fall = ~sync_q[1] & prev_ff[1];
    o_evt.start    = sync_q[1] & prev_ff[1] & prev_ff[0] & ~sync_q[0];
    o_evt.stop     = sync_q[1] & prev_ff[1] & ~prev_ff[0] & sync_q[0];
  end

endmodule : bus_line_sync

`default_nettype wire

//--- ccc_host_model.sv
// Bus host model: drives the clock and data lines of the two-wire bus.
// Assumes the bench merges its data drive with the device's onto a pulled-up wire.
`timescale 1ns/10ps
`default_nettype none

module ccc_host_model (
  output logic      o_scl,
  output logic      o_sda,
  input  wire logic i_sda
);
  // Half bit time in ns; clock rests high outside frames
  real half = 62.5;

  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // Start or repeated Start
  task automatic start();
    o_sda = 1'b1;
    #(half / 2);
    o_scl = 1'b1;
    #(half / 2);
    o_sda = 1'b0;
    #(half / 2);
    o_scl = 1'b0;
    #(half / 2);
  endtask : start

  task automatic stop();
    o_sda = 1'b0;
    #(half / 2);
    o_scl = 1'b1;
    #(half / 2);
    o_sda = 1'b1;
    #half;
  endtask : stop

  // Byte MSB first, then ninth bit; a one releases the line
  task automatic xfer(input logic [7:0] b, input logic nine,
                      output logic [7:0] rd, output logic seen);
    logic [8:0] w;
    w = {b, nine};
    for (int i = 8; i >= 0; i--) begin
      o_sda = w[i];
      #(half / 2);
      o_scl = 1'b1;
      #(half / 2);
      w[i] = i_sda;
      #(half / 2);
      o_scl = 1'b0;
      #(half / 2);
    end
    rd = w[8:1];
    seen = w[0];
  endtask : xfer
endmodule : ccc_host_model

`default_nettype wire

//--- test_ccc_status_caps_handler.sv
// Self-checking bench for the command-code handler against a host model.
// Assumes bus pins are resampled on the falling clock edge, wire pulled up.
`timescale 1ns/10ps
`default_nettype none

module test_ccc_status_caps_handler;
  import ccc_status_caps_pkg::*;

  localparam logic [6:0] OWN_ADDR = 7'h1a;

  logic       clk, rst_n, scl_q, sda_q, pec_en, gclr, chk_c, par_c;
  logic [1:0] clr_wr;
  logic       h_scl, h_sda, sda_out, sda_oe, mode, chk_f, par_f, ibi;
  logic [3:0] pend;
  logic [7:0] exp_q[$];
  int         failures, samples_checked, m_chk, m_par, m_i3c;

  ccc_status_caps_handler ccc_status_caps_handler_i (
    .i_sys_clk(clk), .i_arst_n(rst_n), .i_scl(scl_q), .i_sda(sda_q),
    .i_target_address(OWN_ADDR), .i_pec_en(pec_en), .i_error_clear_wr(clr_wr),
    .i_global_clear(gclr), .i_chk_cond(chk_c), .i_par_cond(par_c),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_mode_i3c(mode),
    .o_checksum_error_flag(chk_f), .o_parity_error_flag(par_f),
    .o_pending_irq(pend), .o_ibi_status(ibi));

  ccc_host_model ccc_host_model_i (.o_scl(h_scl), .o_sda(h_sda), .i_sda(sda_q));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Open-drain wire: released line reads high
  always @(negedge clk) begin
    scl_q <= h_scl;
    sda_q <= h_sda & (sda_oe ? sda_out : 1'b1);
  end

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) r = r[7] ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
    return r;
  endfunction : crc8

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic chk_flags();
    chk("checksum flag", 8'(chk_f), 8'(m_chk));
    chk("parity flag", 8'(par_f), 8'(m_par));
    chk("pending code", 8'(pend), 8'((m_chk | m_par) != 0));
    chk("interrupt status", 8'(ibi), 8'((m_chk | m_par) != 0));
  endtask : chk_flags

  // Set wins over clear in the same cycle
  task automatic drive(input int cc, input int pc, input logic [1:0] w, input logic g);
    @(negedge clk);
    {chk_c, par_c, clr_wr, gclr} = {cc[0], pc[0], w, g};
    @(negedge clk);
    {chk_c, par_c, clr_wr, gclr} = '0;
    m_chk = (w[1] | g) ? cc : (m_chk | cc);
    m_par = (w[0] | g) ? pc : (m_par | pc);
    repeat (4) @(negedge clk);
    chk_flags();
  endtask : drive

  // bad: 1 wrong parity on code, 2 wrong host checksum
  task automatic txn(input logic [7:0] code, input int bad, input logic exp_ack);
    logic [7:0] crc, d;
    logic       t;
    int         n;
    n = exp_q.size() + int'(pec_en);
    ccc_host_model_i.start();
    ccc_host_model_i.xfer({BCAST_ADDR, 1'b0}, 1'b1, d, t);
    chk("broadcast ack", 8'(t), 8'h00);
    ccc_host_model_i.xfer(code, m_i3c ? ((~^code) ^ (bad == 1)) : 1'b1, d, t);
    if (m_i3c == 0) chk("code ack", 8'(t), 8'(exp_ack));
    if (m_i3c != 0 && pec_en) begin
      crc = crc8(CRC_INIT, code) ^ 8'(bad == 2);
      ccc_host_model_i.xfer(crc, ~^crc, d, t);
    end
    if (m_i3c != 0) begin
      ccc_host_model_i.start();
      ccc_host_model_i.xfer({OWN_ADDR, 1'b1}, 1'b1, d, t);
      chk("read address ack", 8'(t), 8'(exp_ack));
      crc = crc8(CRC_INIT, {OWN_ADDR, 1'b1});
      for (int i = 0; i < n && !exp_ack; i++) begin
        ccc_host_model_i.xfer(8'hff, 1'b1, d, t);
        chk("read byte", d, (i < exp_q.size()) ? exp_q[i] : crc);
        chk("transition bit", 8'(t), 8'(i < n - 1));
        if (i < exp_q.size()) crc = crc8(crc, exp_q[i]);
      end
    end
    ccc_host_model_i.stop();
    if (bad == 1) m_par = 1;
    if (bad == 2) m_chk = 1;
    exp_q.delete();
    repeat (4) @(negedge clk);
    chk_flags();
  endtask : txn

  task automatic status_read();
    exp_q = '{8'(m_chk << 7), 8'((m_par << 5) | ((m_chk | m_par) != 0))};
    txn(CODE_GETSTATUS, 0, 1'b0);
  endtask : status_read

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    print_verdict();
  end

  initial begin
    {rst_n, pec_en, gclr, chk_c, par_c, clr_wr} = '0;
    void'($urandom(32'hfbc7));
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    chk("mode after reset", 8'(mode), 8'h00);
    chk_flags();
    txn(CODE_GETSTATUS, 0, 1'b1);
    ccc_host_model_i.half = 500.0;
    pec_en = 1'b1;
    txn(CODE_SETAASA, 0, 1'b0);
    pec_en = 1'b0;
    ccc_host_model_i.half = 62.5;
    ccc_host_model_i.start();
    ccc_host_model_i.stop();
    m_i3c = 1;
    repeat (4) @(negedge clk);
    chk("mode bit", 8'(mode), 8'h01);
    txn(CODE_SETAASA, 0, 1'b1);
    chk("mode bit kept", 8'(mode), 8'h01);
    for (int k = 0; k < 2; k++) begin
      exp_q = '{8'h04, 8'h00};
      txn(CODE_GETCAP, 0, 1'b0);
      status_read();
      pec_en = 1'b1;
    end
    for (int k = 0; k < 6; k++) begin
      drive($urandom % 2, $urandom % 2, 2'b00, 1'b0);
      status_read();
      status_read();
      drive($urandom % 2, $urandom % 2, 2'($urandom), 1'($urandom));
    end
    drive(1, 1, 2'b11, 1'b0);
    drive(0, 0, 2'b00, 1'b1);
    txn(CODE_GETSTATUS, 1, 1'b1);
    drive(0, 0, 2'b01, 1'b0);
    txn(CODE_GETSTATUS, 2, 1'b1);
    drive(0, 0, 2'b10, 1'b0);
    exp_q = '{8'h04, 8'h00};
    txn(CODE_GETCAP, 0, 1'b0);
    print_verdict();
  end
endmodule : test_ccc_status_caps_handler

`default_nettype wire
